// *** rtl/etd_pkg.sv ***
// transmit descriptor decode: shared constants and carrier types
// assumes one 40 MHz clock domain and an AXI4-Lite register master
package etd_pkg;
  // descriptor word 1 field positions
  localparam int unsigned W1_CHAIN_BIT = 31;
  localparam int unsigned W1_VIRT_BIT  = 30;
  localparam int unsigned W1_TYPE_HI   = 29;
  localparam int unsigned W1_TYPE_LO   = 28;
  localparam int unsigned W1_NOCRC_BIT = 27;
  localparam int unsigned W1_FIRST_BIT = 26;
  localparam int unsigned W1_LAST_BIT  = 25;
  localparam int unsigned W1_IRQ_BIT   = 24;
  localparam int unsigned W1_VTYPE_BIT = 23;
  // descriptor word 2 field positions
  localparam int unsigned W2_COUNT_HI  = 30;
  localparam int unsigned W2_COUNT_LO  = 16;
  localparam int unsigned W2_OFFS_HI   = 8;
  localparam int unsigned W2_OFFS_LO   = 0;
  // frame shorter than this is padded and always gets a crc
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS    = 8'h00;
  localparam logic [7:0] OFS_MASK      = 8'h04;
  localparam logic [7:0] OFS_FRAME_LEN = 8'h08;
  localparam logic [7:0] OFS_CTRL      = 8'h0c;
  // status / mask bit positions
  localparam int unsigned ST_TX_IRQ  = 0;
  localparam int unsigned ST_SKIPPED = 1;
  localparam int unsigned ST_BADTYPE = 2;
  // reset values, response codes and the undefined content code
  localparam logic [2:0]  MASK_RST = 3'h0;
  localparam logic        CTRL_RST = 1'b0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [1:0]  TYPE_BADCODE = 2'h1;

  typedef enum logic [1:0] {ETD_PHYS, ETD_SVPTE, ETD_PHYSICAL_PTE_ADDRESS, ETD_CHAIN} etd_kind_t;

  typedef struct packed {
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
  } etd_desc_t;

  typedef struct packed {
    etd_kind_t   kind;
    logic [31:0] addr;
    logic [14:0] count;
    logic [8:0]  offset;
    logic [1:0]  content;
    logic        first;
    logic        last;
  } etd_seg_t;

  typedef struct packed {
    logic [15:0] len;
    logic        append_crc;
    logic        pad;
    logic        irq_req;
  } etd_frame_t;
endpackage : etd_pkg

// *** rtl/etd_decode.sv ***
// transmit descriptor control-word decoder with AXI4-Lite status registers
// assumes descriptors arrive already fetched, one at a time, and that the
// transmitter pulses tx_done once per frame in the order frames were closed
`timescale 1ns/1ps
module etd_decode (
  input  wire logic               aclk,        // system clock, 40 MHz
  input  wire logic               aresetn,     // sync reset, active low
  input  wire logic               dsc_valid,   // descriptor words offered
  input  wire etd_pkg::etd_desc_t dsc,         // words 1..3
  output logic                    dsc_ready,   // descriptor taken
  output logic                    seg_valid,   // segment command offered
  output etd_pkg::etd_seg_t       seg,         // segment command
  input  wire logic               seg_ready,   // fetch side takes segment
  output logic                    frame_valid, // one-cycle frame summary
  output etd_pkg::etd_frame_t     frame,       // frame summary
  input  wire logic               tx_done,     // frame left the wire
  output logic                    irq,         // level interrupt
  input  wire logic [7:0]         awaddr,      // axi write address
  input  wire logic               awvalid,     // axi
  output logic                    awready,     // axi
  input  wire logic [31:0]        wdata,       // axi
  input  wire logic [3:0]         wstrb,       // axi
  input  wire logic               wvalid,      // axi
  output logic                    wready,      // axi
  output logic [1:0]              bresp,       // axi
  output logic                    bvalid,      // axi
  input  wire logic               bready,      // axi
  input  wire logic [7:0]         araddr,      // axi read address
  input  wire logic               arvalid,     // axi
  output logic                    arready,     // axi
  output logic [31:0]             rdata,       // axi
  output logic [1:0]              rresp,       // axi
  output logic                    rvalid,      // axi
  input  wire logic               rready       // axi
);
  import etd_pkg::*;

  // addressing kind from word 1; chain takes precedence over buffer modes
  function automatic etd_kind_t addr_kind(input logic [31:0] w1);
    if (w1[W1_CHAIN_BIT])      addr_kind = ETD_CHAIN;
    else if (!w1[W1_VIRT_BIT]) addr_kind = ETD_PHYS;
    else if (w1[W1_VTYPE_BIT]) addr_kind = ETD_SVPTE;
    else                       addr_kind = ETD_PHYSICAL_PTE_ADDRESS;
  endfunction : addr_kind

  etd_seg_t    seg_reg, seg_next;
  logic        seg_valid_reg;
  logic        dsc_ready_reg;
  etd_frame_t  frame_reg;
  logic        frame_valid_reg;
  logic [15:0] len_reg;
  logic        nocrc_reg;
  logic        cmpl_pend_reg;
  logic [2:0]  status_reg, status_next;
  logic [2:0]  mask_reg;
  logic        ctrl_en_reg;
  logic [15:0] last_len_reg;
  logic        irq_reg;

  // field decode; bits 22:0 of word 1 and bit 31 of word 2 are never looked at
  wire         take      = dsc_valid && dsc_ready_reg;
  wire         is_first  = dsc.w1[W1_FIRST_BIT];
  wire         is_last   = dsc.w1[W1_LAST_BIT];
  wire         is_virt   = dsc.w1[W1_VIRT_BIT];
  wire [14:0]  count     = dsc.w2[W2_COUNT_HI:W2_COUNT_LO];
  wire [1:0]   content   = dsc.w1[W1_TYPE_HI:W1_TYPE_LO];
  wire         is_chain  = dsc.w1[W1_CHAIN_BIT];
  wire         zero_len  = (count == 15'h0000) && !is_chain;
  wire         bad_type  = (content == TYPE_BADCODE);
  wire         emit      = take && !zero_len;
  // running frame length; a first segment restarts the sum
  wire [15:0]  len_base  = is_first ? 16'h0000 : len_reg;
  wire [15:0]  len_sum   = is_chain ? len_base : len_base + {1'b0, count};
  wire         nocrc_now = is_first ? dsc.w1[W1_NOCRC_BIT] : nocrc_reg;
  wire         short_frm = len_sum < MIN_FRAME_BYTES;
  wire         close_frm = take && is_last && !is_chain;
  wire         cmpl_now  = close_frm && dsc.w1[W1_IRQ_BIT];

  // segment command: word 3 passes whole, no alignment trimmed off
  always_comb begin
    seg_next         = seg_reg;
    seg_next.kind    = addr_kind(dsc.w1);
    seg_next.addr    = dsc.w3;
    seg_next.count   = count;
    seg_next.offset  = is_virt ? dsc.w2[W2_OFFS_HI:W2_OFFS_LO] : 9'h000;
    seg_next.content = content;
    seg_next.first   = is_first;
    seg_next.last    = is_last;
  end

  // one descriptor in flight; ready returns once the segment is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsc_ready_reg <= 1'b0;
      seg_valid_reg <= 1'b0;
      seg_reg       <= '0;
    end else begin
      if (emit) begin
        seg_valid_reg <= 1'b1;
        seg_reg       <= seg_next;
        dsc_ready_reg <= 1'b0;
      end else if (seg_valid_reg && seg_ready) begin
        seg_valid_reg <= 1'b0;
        dsc_ready_reg <= ctrl_en_reg;
      end else if (!seg_valid_reg) begin
        dsc_ready_reg <= ctrl_en_reg && !take;
      end
    end
  end

  // frame bookkeeping; short frames force pad and crc
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_reg         <= 16'h0000;
      nocrc_reg       <= 1'b0;
      frame_valid_reg <= 1'b0;
      frame_reg       <= '0;
      last_len_reg    <= 16'h0000;
    end else begin
      frame_valid_reg <= close_frm;
      if (take) begin
        len_reg   <= len_sum;
        nocrc_reg <= nocrc_now;
      end
      if (close_frm) begin
        frame_reg.len        <= len_sum;
        frame_reg.pad        <= short_frm;
        frame_reg.append_crc <= short_frm || !nocrc_now;
        frame_reg.irq_req    <= dsc.w1[W1_IRQ_BIT];
        last_len_reg         <= len_sum;
      end
    end
  end

  // completion interrupt waits for the wire; a new request wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn)      cmpl_pend_reg <= 1'b0;
    else if (cmpl_now) cmpl_pend_reg <= 1'b1;
    else if (tx_done)  cmpl_pend_reg <= 1'b0;
  end

  // axi4-lite slave: one write and one read at a time
  logic        aw_have_reg, w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  wire         do_write  = aw_have_reg && w_have_reg && !bvalid_reg;
  wire         do_read   = arvalid && arready_reg;
  wire         wr_ok     = (aw_addr_reg == OFS_MASK) || (aw_addr_reg == OFS_CTRL);
  wire         rd_status = do_read && (araddr == OFS_STATUS);
  wire [2:0]   ev_set    = {take && bad_type, take && zero_len, tx_done && cmpl_pend_reg};
  wire         rd_ok     = (araddr == OFS_STATUS) || (araddr == OFS_MASK) ||
                           (araddr == OFS_FRAME_LEN) || (araddr == OFS_CTRL);
  wire [31:0]  rd_mux    = (araddr == OFS_STATUS)    ? {29'h0, status_reg} :
                           (araddr == OFS_MASK)      ? {29'h0, mask_reg} :
                           (araddr == OFS_FRAME_LEN) ? {16'h0, last_len_reg} :
                           (araddr == OFS_CTRL)      ? {31'h0, ctrl_en_reg} : 32'h0;

  // read of status clears it, but an event in the same cycle survives
  assign status_next = (rd_status ? 3'h0 : status_reg) | ev_set;

  // write address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      awready_reg <= !aw_have_reg && !(awvalid && awready_reg);
      wready_reg  <= !w_have_reg && !(wvalid && wready_reg);
      if (awvalid && awready_reg) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_write) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
      end
    end
  end

  // register file and interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg  <= 3'h0;
      mask_reg    <= MASK_RST;
      ctrl_en_reg <= CTRL_RST;
      irq_reg     <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= |(status_next & mask_reg);
      if (do_write && w_strb_reg[0] && aw_addr_reg == OFS_MASK) mask_reg    <= w_data_reg[2:0];
      if (do_write && w_strb_reg[0] && aw_addr_reg == OFS_CTRL) ctrl_en_reg <= w_data_reg[0];
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_reg && !do_read;
      if (do_read) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_mux;
        rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign dsc_ready   = dsc_ready_reg;
  assign seg_valid   = seg_valid_reg;
  assign seg         = seg_reg;
  assign frame_valid = frame_valid_reg;
  assign frame       = frame_reg;
  assign irq         = irq_reg;
  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;

  // checks
  sequence s_take;
    dsc_valid && dsc_ready;
  endsequence
  sequence s_buf;
    s_take ##0 (!dsc.w1[W1_CHAIN_BIT] && dsc.w2[W2_COUNT_HI:W2_COUNT_LO] != 15'h0000);
  endsequence

  a_crc_disable_first: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dsc.w1[W1_FIRST_BIT] && dsc.w1[W1_LAST_BIT] && !dsc.w1[W1_CHAIN_BIT] &&
    dsc.w2[W2_COUNT_HI:W2_COUNT_LO] >= 15'h0040) |=> frame_valid && frame.append_crc != $past(dsc.w1[W1_NOCRC_BIT]))
    else $error("crc disable not taken from first segment");
  a_short_frame_pad: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_valid && frame.len < MIN_FRAME_BYTES |-> frame.pad && frame.append_crc)
    else $error("short frame without pad and crc");
  a_single_seg_len: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dsc.w1[W1_FIRST_BIT] && dsc.w1[W1_LAST_BIT] && !dsc.w1[W1_CHAIN_BIT])
    |=> frame.len == {1'b0, $past(dsc.w2[W2_COUNT_HI:W2_COUNT_LO])})
    else $error("frame length wrong");
  a_last_closes_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dsc.w1[W1_LAST_BIT] && !dsc.w1[W1_CHAIN_BIT]) |=> frame_valid ##1 !frame_valid)
    else $error("last segment did not close one frame");
  a_irq_on_last_only: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dsc.w1[W1_LAST_BIT] && !dsc.w1[W1_CHAIN_BIT]) |=> frame.irq_req == $past(dsc.w1[W1_IRQ_BIT]))
    else $error("interrupt request not tied to last segment");
  a_cmpl_pend_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dsc.w1[W1_LAST_BIT] && !dsc.w1[W1_CHAIN_BIT] && dsc.w1[W1_IRQ_BIT]) |=> cmpl_pend_reg)
    else $error("completion request not held for the wire");
  a_tx_irq_status: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_done && cmpl_pend_reg |=> status_reg[ST_TX_IRQ] ##1 (irq || !(status_reg[ST_TX_IRQ] && $past(mask_reg[ST_TX_IRQ]))))
    else $error("transmit interrupt flag not set");
  a_zero_len_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (!dsc.w1[W1_CHAIN_BIT] && dsc.w2[W2_COUNT_HI:W2_COUNT_LO] == 15'h0000) |=> !seg_valid)
    else $error("zero length buffer not skipped");
  a_addr_kind_virt: assert property (@(posedge aclk) disable iff (!aresetn)
    s_buf ##0 dsc.w1[W1_VIRT_BIT] |=> seg_valid &&
    seg.kind == ($past(dsc.w1[W1_VTYPE_BIT]) ? ETD_SVPTE : ETD_PHYSICAL_PTE_ADDRESS) && seg.addr == $past(dsc.w3))
    else $error("virtual address kind wrong");
  a_addr_phys: assert property (@(posedge aclk) disable iff (!aresetn)
    s_buf ##0 !dsc.w1[W1_VIRT_BIT] |=> seg.kind == ETD_PHYS && seg.offset == 9'h000 && seg.addr == $past(dsc.w3))
    else $error("physical buffer address wrong");
  a_chain_next: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 dsc.w1[W1_CHAIN_BIT] |=> seg_valid && seg.kind == ETD_CHAIN && seg.addr == $past(dsc.w3))
    else $error("chain address not forwarded");

  // interrupt line updates on the same edge as status, so it is held against last cycle's mask
  a_irq_level_out: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(status_reg & $past(mask_reg)))
    else $error("interrupt line does not follow status and mask");

  // descriptor side: one in flight, fields carried through unchanged
  a_ready_drops_take: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take |=> !dsc_ready)
    else $error("descriptor port still ready after take");
  a_seg_flags_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_buf |=> seg.first == $past(dsc.w1[W1_FIRST_BIT]) && seg.last == $past(dsc.w1[W1_LAST_BIT]))
    else $error("segment flags not taken from word 1");
  a_seg_fields_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_buf |=> seg.count == $past(dsc.w2[W2_COUNT_HI:W2_COUNT_LO]) &&
    seg.content == $past(dsc.w1[W1_TYPE_HI:W1_TYPE_LO]))
    else $error("segment count or content type wrong");
  a_virt_offset: assert property (@(posedge aclk) disable iff (!aresetn)
    s_buf ##0 dsc.w1[W1_VIRT_BIT] |=> seg.offset == $past(dsc.w2[W2_OFFS_HI:W2_OFFS_LO]))
    else $error("page offset not passed in virtual mode");
  a_seg_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    seg_valid && !seg_ready |=> seg_valid && $stable(seg))
    else $error("segment command changed while waiting");

  // status events: set lands on the edge after the take
  a_skip_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (!dsc.w1[W1_CHAIN_BIT] && dsc.w2[W2_COUNT_HI:W2_COUNT_LO] == 15'h0000) |=> status_reg[ST_SKIPPED])
    else $error("skipped buffer not flagged");
  a_bad_type_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take ##0 (dsc.w1[W1_TYPE_HI:W1_TYPE_LO] == TYPE_BADCODE) |=> status_reg[ST_BADTYPE])
    else $error("undefined content code not flagged");

  // register bus answers stand until taken
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped before taken");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before taken");
endmodule : etd_decode

// *** test/etd_host_model.sv ***
// host side model: offers fetched descriptors one at a time, drains segments
// assumes the decoder samples on rising aclk; slow makes the consumer stall
`timescale 1ns/1ps
module etd_host_model (
  input  wire logic          aclk,      // system clock
  input  wire logic          slow,      // stall the segment consumer
  output etd_pkg::etd_desc_t dsc,       // descriptor words 1..3
  output logic               dsc_valid, // descriptor offered
  input  wire logic          dsc_ready, // descriptor taken
  output logic               seg_ready  // segment consumer ready
);
  import etd_pkg::*;

  initial begin
    dsc_valid = 1'b0;
    dsc       = '0;
    seg_ready = 1'b0;
  end

  // slow consumer toggles ready so segments can wait up to a cycle
  always @(posedge aclk) begin
    seg_ready <= slow ? ~seg_ready : 1'b1;
  end

  // words are complete before hand-over and never change while offered
  task send(input etd_desc_t d);
    dsc       <= d;
    dsc_valid <= 1'b1;
    do @(posedge aclk); while (dsc_ready !== 1'b1);
    dsc_valid <= 1'b0;
    dsc       <= ~d; // released words show junk, not the last value
    @(posedge aclk);
  endtask : send
endmodule : etd_host_model

// *** test/etd_decode_tb.sv ***
// self-checking bench for the transmit descriptor decoder
// assumes etd_host_model on the descriptor side and an axi4-lite master here
`timescale 1ns/1ps
module etd_decode_tb;
  import etd_pkg::*;
  logic        aclk, aresetn, slow, tx_done, irq;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        dsc_valid, dsc_ready, seg_valid, seg_ready, frame_valid;
  etd_desc_t   dsc;
  etd_seg_t    seg;
  etd_frame_t  frame;
  etd_seg_t    seg_q[$];
  etd_frame_t  frm_q[$];
  etd_desc_t   dl[$];
  int          error_cnt, checks_done, cyc;

  etd_decode etd_decode_i (.aclk, .aresetn, .dsc_valid, .dsc, .dsc_ready, .seg_valid, .seg, .seg_ready,
    .frame_valid, .frame, .tx_done, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  etd_host_model etd_host_model_i (.aclk, .slow, .dsc, .dsc_valid, .dsc_ready, .seg_ready);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // collect segments and frame summaries; cut a hang short
  always @(posedge aclk) begin
    if (seg_valid && seg_ready) seg_q.push_back(seg);
    if (frame_valid) frm_q.push_back(frame);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one write: address and data offered together, each released when taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    chk("bresp", er, rsp);
  endtask : axi_wr

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    chk(nm, e, rd);
    chk("rresp", er, rsp);
  endtask : rchk

  // f is word 1 bits 31:23; junk in the unused bits must change nothing
  function automatic etd_desc_t mk(input logic [8:0] f, input logic [14:0] n, input logic [8:0] offs,
                                   input logic [31:0] a);
    return {f, 23'h2a5a5a, 1'b1, n, 7'h5b, offs, a};
  endfunction : mk

  function automatic etd_seg_t exp_seg(input etd_desc_t d);
    etd_seg_t s;
    s.kind    = d.w1[31] ? ETD_CHAIN : !d.w1[30] ? ETD_PHYS : d.w1[23] ? ETD_SVPTE : ETD_PHYSICAL_PTE_ADDRESS;
    s.addr    = d.w3;
    s.count   = d.w2[30:16];
    s.offset  = d.w1[30] ? d.w2[8:0] : 9'h000;
    s.content = d.w1[29:28];
    s.first   = d.w1[26];
    s.last    = d.w1[25];
    return s;
  endfunction : exp_seg

  // send the list in dl, then compare segments and the frame summary
  task run_frame();
    etd_frame_t ef;
    etd_seg_t   es;
    int         n, ns;
    ef = '0;
    ns = 0;
    seg_q.delete();
    frm_q.delete();
    foreach (dl[i]) begin
      if (dl[i].w1[26]) ef.append_crc = !dl[i].w1[27];
      if (dl[i].w1[25]) ef.irq_req = dl[i].w1[24];
      if (!dl[i].w1[31]) ef.len = ef.len + 16'(dl[i].w2[30:16]); // chain words add nothing
      if (dl[i].w1[31] || dl[i].w2[30:16] != 15'h0) ns++;
      etd_host_model_i.send(dl[i]);
    end
    ef.pad = ef.len < MIN_FRAME_BYTES;
    if (ef.pad) ef.append_crc = 1'b1;
    for (n = 0; n < 500 && (frm_q.size() == 0 || seg_q.size() < ns); n++) @(posedge aclk);
    chk("seg_count", 64'(ns), 64'(seg_q.size()));
    chk("frame_count", 64'h1, 64'(frm_q.size()));
    if (frm_q.size() > 0) chk("frame", 64'(ef), 64'(frm_q[0]));
    foreach (dl[i]) if (seg_q.size() > 0 && (dl[i].w1[31] || dl[i].w2[30:16] != 15'h0)) begin
      es = exp_seg(dl[i]);
      if (es.kind == ETD_CHAIN) chk("chain", {es.kind, es.addr}, {seg_q[0].kind, seg_q[0].addr});
      else chk("seg", 64'(es), 64'(seg_q[0]));
      seg_q.pop_front();
    end
  endtask : run_frame

  task pulse_tx();
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_tx

  // main sequence
  initial begin
    aresetn     = 1'b0;
    slow        = 1'b0;
    tx_done     = 1'b0;
    awaddr      = 8'h00;
    araddr      = 8'h00;
    awvalid     = 1'b0;
    wvalid      = 1'b0;
    bready      = 1'b0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    wdata       = 32'h0;
    wstrb       = 4'h0;
    error_cnt   = 0;
    checks_done = 0;
    cyc         = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("status", OFS_STATUS, 32'h0, RESP_OKAY);
    rchk("mask", OFS_MASK, {29'h0, MASK_RST}, RESP_OKAY);
    rchk("ctrl", OFS_CTRL, {31'h0, CTRL_RST}, RESP_OKAY);
    rchk("unmapped", 8'h10, 32'h0, RESP_SLVERR);
    axi_wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
    chk("ready_off", 64'h0, 64'(dsc_ready));
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
    // single segment, crc off, completion request, odd start address
    dl = {mk(9'h01e, 15'd100, 9'h1ff, 32'h1000_0003)};
    run_frame();
    rchk("frame_len", OFS_FRAME_LEN, 32'd100, RESP_OKAY);
    pulse_tx();
    chk("irq_masked", 64'h0, 64'(irq));
    axi_wr(OFS_MASK, 32'h7, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq_on", 64'h1, 64'(irq));
    rchk("status", OFS_STATUS, 32'h1, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq_off", 64'h0, 64'(irq));
    rchk("status", OFS_STATUS, 32'h0, RESP_OKAY);
    // four descriptors with a skipped and a chained one, slow consumer; crc off only on first
    slow <= 1'b1;
    dl = {mk(9'h01a, 15'd40, 9'h000, 32'h1000_0100), mk(9'h000, 15'd0, 9'h000, 32'h1000_0200),
          mk(9'h100, 15'd0, 9'h000, 32'h2000_0040), mk(9'h085, 15'd30, 9'h123, 32'h8000_1234)};
    run_frame();
    slow <= 1'b0;
    pulse_tx();
    rchk("status", OFS_STATUS, 32'h2, RESP_OKAY);
    // content code 01, exactly minimum length, physical pte
    dl = {mk(9'h0ac, 15'd64, 9'h0f1, 32'h0000_8000)};
    run_frame();
    rchk("frame_len", OFS_FRAME_LEN, 32'd64, RESP_OKAY);
    rchk("status", OFS_STATUS, 32'h4, RESP_OKAY);
    // setup and diagnostic codes, one byte short of minimum
    dl = {mk(9'h048, 15'd1, 9'h000, 32'h0000_0011), mk(9'h066, 15'd62, 9'h000, 32'h0000_0013)};
    run_frame();
    pulse_tx();
    rchk("status", OFS_STATUS, 32'h1, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("ready_off", 64'h0, 64'(dsc_ready));
    // mid-run reset: mask and last length must fall back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("mask_rst", OFS_MASK, {29'h0, MASK_RST}, RESP_OKAY);
    rchk("len_rst", OFS_FRAME_LEN, 32'h0, RESP_OKAY);
    rchk("status_rst", OFS_STATUS, 32'h0, RESP_OKAY);
    end_sim();
  end
endmodule : etd_decode_tb
